// file: hdl/cpuas_pkg.sv
// package: constants, opcodes and states of the 8-bit core datapath
package cpuas_pkg;
    localparam int unsigned CPUAS_NREG = 32;
    localparam int unsigned CPUAS_NIRQ = 8;
    // status bit positions
    localparam int unsigned FL_I = 7;
    localparam int unsigned FL_T = 6;
    localparam int unsigned FL_H = 5;
    localparam int unsigned FL_S = 4;
    localparam int unsigned FL_V = 3;
    localparam int unsigned FL_N = 2;
    localparam int unsigned FL_Z = 1;
    localparam int unsigned FL_C = 0;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] STACK_RST = 16'h0000;
    localparam logic [15:0] PROG_RST = 16'h0000;
    // data space: register file below, then 64 i/o locations
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [5:0] IO_FLAGS = 6'h30;
    localparam logic [5:0] IO_STK_LO = 6'h31;
    localparam logic [5:0] IO_STK_HI = 6'h32;
    localparam logic [15:0] DA_FLAGS = IO_BASE + 16'(IO_FLAGS);
    localparam logic [15:0] DA_STK_LO = IO_BASE + 16'(IO_STK_LO);
    localparam logic [15:0] DA_STK_HI = IO_BASE + 16'(IO_STK_HI);
    localparam logic [4:0] PTR_X = 5'h1a;
    localparam logic [4:0] PTR_Y = 5'h1c;
    localparam logic [4:0] PTR_Z = 5'h1e;
    localparam logic [15:0] VEC_WORDS = 16'h0002;
    // instruction word fields
    localparam int unsigned OP_LSB = 11;
    localparam int unsigned RD_LSB = 6;
    localparam int unsigned RR_LSB = 1;
    localparam int unsigned OFF_LSB = 3;
    localparam int unsigned CND_BIT = 10;
    // opcodes; unlisted codes do nothing
    localparam logic [4:0] OP_ADD = 5'h01;
    localparam logic [4:0] OP_ADC = 5'h02;
    localparam logic [4:0] OP_SUB = 5'h03;
    localparam logic [4:0] OP_SBC = 5'h04;
    localparam logic [4:0] OP_AND = 5'h05;
    localparam logic [4:0] OP_OR = 5'h06;
    localparam logic [4:0] OP_EOR = 5'h07;
    localparam logic [4:0] OP_MOV = 5'h08;
    localparam logic [4:0] OP_CP = 5'h09;
    localparam logic [4:0] OP_SUBI = 5'h0a;
    localparam logic [4:0] OP_ANDI = 5'h0b;
    localparam logic [4:0] OP_LDI = 5'h0c;
    localparam logic [4:0] OP_INC = 5'h0d;
    localparam logic [4:0] OP_DEC = 5'h0e;
    localparam logic [4:0] OP_COM = 5'h0f;
    localparam logic [4:0] OP_LSR = 5'h10;
    localparam logic [4:0] OP_BITOUT = 5'h11;
    localparam logic [4:0] OP_BITIN = 5'h12;
    localparam logic [4:0] OP_GIE = 5'h13;
    localparam logic [4:0] OP_JMP = 5'h14;
    localparam logic [4:0] OP_CALL = 5'h15;
    localparam logic [4:0] OP_RET = 5'h16;
    localparam logic [4:0] OP_BRF = 5'h17;
    localparam logic [4:0] OP_LDP = 5'h18;
    localparam logic [4:0] OP_STP = 5'h19;
    localparam logic [4:0] OP_LPM = 5'h1a;
    localparam logic [4:0] OP_IN = 5'h1b;
    localparam logic [4:0] OP_OUT = 5'h1c;
    localparam logic [4:0] OP_PUSH = 5'h1d;
    localparam logic [4:0] OP_POP = 5'h1e;
    typedef enum logic [2:0] {
        ST_EXEC, ST_PUSH2, ST_POP1, ST_POP2, ST_LOAD, ST_LPM
    } cpuas_state_t;
endpackage : cpuas_pkg

// file: hdl/cpuas_core.sv
// core datapath: prefetch, register file, alu, status flags and stack
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: next word is fetched while the current one executes.
// RULE_02: thirty-two 8-bit registers, each read or written in one cycle.
// RULE_03: two-operand alu op reads, computes and writes back in one cycle.
// RULE_04: registers 26..31 form three 16-bit pointers; Z also reads flash.
// RULE_05: alu does arithmetic, logic and bit ops on regs or immediates.
// RULE_06: alu ops update status flags describing the result.
// RULE_07: status is never saved or restored on interrupt entry or return.
// RULE_08: with global enable clear no interrupt is ever taken.
// RULE_09: interrupt entry clears global enable; return from handler sets it.
// RULE_10: dedicated instructions set or clear the global enable.
// RULE_11: bit 6 receives a register bit and gives it back to a register.
// RULE_12: bit 5 holds carry out of the low nibble.
// RULE_13: sign bit always equals negative xor overflow.
// RULE_14: bit 3 flags two's complement overflow.
// RULE_15: bits 2,1,0 flag negative, zero and carry.
// RULE_16: each source has a vector; the lowest vector wins.
// RULE_17: 64 i/o locations follow the register file in data space.
// RULE_18: calls and interrupts push the return address onto the sram stack.
// RULE_19: software sets the stack pointer before calls or interrupts.
// RULE_20: instructions are one or two 16-bit words.
// RULE_21: data push lowers stack pointer by one, return push by two.
// RULE_22: reset clears every status bit, global enable included.
module cpuas_core (
    input wire logic mclk,
    input wire logic srst,
    output logic [15:0] pm_addr,
    input wire logic [15:0] pm_data,
    output logic [15:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    output logic dm_re,
    input wire logic [7:0] dm_rdata,
    input wire logic [cpuas_pkg::CPUAS_NIRQ-1:0] irq_req,
    output logic [cpuas_pkg::CPUAS_NIRQ-1:0] irq_ack,
    output logic [7:0] status_flags
);
    import cpuas_pkg::*;
    default clocking cb_main @(posedge mclk);
    endclocking
    default disable iff (srst);

    cpuas_state_t state_ff, nxt_state;
    logic [15:0] program_counter_ff, nxt_program_counter;
    logic [15:0] pm_addr_ff, nxt_pm_addr;
    logic [15:0] ir_ff, nxt_ir;
    logic ir_valid_ff, nxt_ir_valid;
    logic [15:0] stack_top_pointer_ff, nxt_stack_top_pointer;
    logic [15:0] ret_ff, nxt_ret;
    logic [7:0] status_flags_ff, nxt_status_flags;
    logic [15:0] dm_addr_ff, nxt_dm_addr;
    logic [7:0] dm_wdata_ff, nxt_dm_wdata;
    logic dm_we_ff, nxt_dm_we;
    logic dm_re_ff, nxt_dm_re;
    logic [CPUAS_NIRQ-1:0] irq_ack_ff, nxt_irq_ack;
    logic [4:0] ld_rd_ff, nxt_ld_rd;
    logic hi_byte_ff, nxt_hi_byte;
    logic ret_irq_ff, nxt_ret_irq;
    logic [7:0] gpr_ff [CPUAS_NREG];
    logic rf_we;
    logic [4:0] rf_wa;
    logic [7:0] rf_wd;
    logic [4:0] op, rd, rr, pbase;
    logic [2:0] bsel;
    logic [7:0] a, b, imm, int_val;
    logic [15:0] ptr, zptr, ls_addr, vec, stp, boff;
    logic is_load, is_store, two_word, take_irq, int_hit, run;
    logic [CPUAS_NIRQ-1:0] irq_pick;
    logic sub, cuse, c_out, h_out, v_out, setnz, alu_wr;
    logic [7:0] bsrc, bx, alu_res, alu_flags;
    logic [8:0] sum9;
    logic [4:0] nib;

    assign pm_addr = pm_addr_ff;
    assign dm_addr = dm_addr_ff;
    assign dm_wdata = dm_wdata_ff;
    assign dm_we = dm_we_ff;
    assign dm_re = dm_re_ff;
    assign irq_ack = irq_ack_ff;
    assign status_flags = status_flags_ff;

    assign stp = stack_top_pointer_ff;
    assign op = ir_ff[OP_LSB +: 5];
    assign rd = ir_ff[RD_LSB +: 5];
    assign rr = ir_ff[RR_LSB +: 5];
    assign bsel = ir_ff[2:0];
    assign a = gpr_ff[rd];
    assign b = gpr_ff[rr];
    // the second word of a two-word op is on pm_data while the first runs
    assign imm = pm_data[7:0];
    assign boff = {{9{ir_ff[OFF_LSB+6]}}, ir_ff[OFF_LSB +: 7]};
    assign pbase = (ir_ff[1:0] == 2'b00) ? PTR_X :
                   (ir_ff[1:0] == 2'b01) ? PTR_Y : PTR_Z;
    assign ptr = {gpr_ff[pbase + 5'h01], gpr_ff[pbase]}; // RULE_04
    assign zptr = {gpr_ff[PTR_Z + 5'h01], gpr_ff[PTR_Z]}; // RULE_04
    assign is_load = (op == OP_LDP) || (op == OP_IN) || (op == OP_POP);
    assign is_store = (op == OP_STP) || (op == OP_OUT) || (op == OP_PUSH);
    assign ls_addr = (op == OP_IN || op == OP_OUT) ?
                     IO_BASE + {10'h000, ir_ff[5:0]} : // RULE_17
                     (op == OP_POP) ? stp + 16'h0001 :
                     (op == OP_PUSH) ? stp : ptr;
    // low data addresses alias the register file, then internal i/o
    assign int_hit = (ls_addr < IO_BASE) || (ls_addr == DA_FLAGS)
                     || (ls_addr == DA_STK_LO) || (ls_addr == DA_STK_HI);
    assign int_val = (ls_addr < IO_BASE) ? gpr_ff[ls_addr[4:0]] :
                     (ls_addr == DA_FLAGS) ? status_flags_ff :
                     (ls_addr == DA_STK_LO) ? stp[7:0] : stp[15:8];
    assign two_word = (op == OP_SUBI) || (op == OP_ANDI) || (op == OP_LDI)
                      || (op == OP_JMP) || (op == OP_CALL); // RULE_20
    // only at a real instruction boundary, so a second word is never lost
    assign take_irq = (state_ff == ST_EXEC) && ir_valid_ff
                      && status_flags_ff[FL_I] && (irq_req != '0); // RULE_08
    assign run = (state_ff == ST_EXEC) && ir_valid_ff && !take_irq;

    always_comb begin : irq_prio
        irq_pick = '0;
        vec = VEC_WORDS;
        for (int i = CPUAS_NIRQ - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                irq_pick = '0;
                irq_pick[i] = 1'b1; // RULE_16
                vec = 16'(i + 1) * VEC_WORDS;
            end
        end
    end

    always_comb begin : alu
        sub = (op == OP_SUB) || (op == OP_SBC) || (op == OP_CP)
              || (op == OP_SUBI) || (op == OP_DEC);
        bsrc = (op == OP_SUBI) ? imm :
               (op == OP_INC || op == OP_DEC) ? 8'h01 : b;
        bx = sub ? ~bsrc : bsrc;
        cuse = (op == OP_ADC || op == OP_SBC) ? status_flags_ff[FL_C] : 1'b0;
        // subtract as a + ~b + 1, borrow is the inverted carry
        sum9 = {1'b0, a} + {1'b0, bx} + {8'h00, sub ^ cuse};
        nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub ^ cuse};
        c_out = sum9[8] ^ sub;
        h_out = nib[4] ^ sub; // RULE_12
        v_out = (a[7] == bx[7]) && (sum9[7] != a[7]); // RULE_14
        alu_res = sum9[7:0];
        alu_flags = status_flags_ff;
        alu_wr = 1'b0;
        setnz = 1'b0;
        case (op) // RULE_05
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SUBI, OP_CP: begin
                alu_wr = (op != OP_CP);
                setnz = 1'b1;
                alu_flags[FL_C] = c_out; // RULE_15
                alu_flags[FL_H] = h_out; // RULE_12
                alu_flags[FL_V] = v_out;
            end
            OP_INC, OP_DEC: begin
                alu_wr = 1'b1;
                setnz = 1'b1;
                alu_flags[FL_V] = v_out;
            end
            OP_AND, OP_ANDI, OP_OR, OP_EOR: begin
                alu_res = (op == OP_OR) ? (a | b) :
                          (op == OP_EOR) ? (a ^ b) :
                          (a & ((op == OP_ANDI) ? imm : b));
                alu_wr = 1'b1;
                setnz = 1'b1;
                alu_flags[FL_V] = 1'b0;
            end
            OP_COM: begin
                alu_res = ~a;
                alu_wr = 1'b1;
                setnz = 1'b1;
                alu_flags[FL_C] = 1'b1;
                alu_flags[FL_V] = 1'b0;
            end
            OP_LSR: begin
                alu_res = {1'b0, a[7:1]};
                alu_wr = 1'b1;
                setnz = 1'b1;
                alu_flags[FL_C] = a[0];
                alu_flags[FL_V] = a[0];
            end
            OP_MOV: begin
                alu_res = b;
                alu_wr = 1'b1;
            end
            OP_LDI: begin
                alu_res = imm;
                alu_wr = 1'b1;
            end
            OP_BITOUT: alu_flags[FL_T] = a[bsel]; // RULE_11
            OP_BITIN: begin
                alu_res = a;
                alu_res[bsel] = status_flags_ff[FL_T]; // RULE_11
                alu_wr = 1'b1;
            end
            OP_GIE: alu_flags[FL_I] = ir_ff[0]; // RULE_10
            default: ;
        endcase
        if (setnz) begin // RULE_06
            alu_flags[FL_N] = alu_res[7]; // RULE_15
            alu_flags[FL_Z] = (alu_res == 8'h00); // RULE_15
        end
    end

    always_comb begin : seq_next
        nxt_state = state_ff;
        nxt_program_counter = program_counter_ff;
        nxt_pm_addr = pm_addr_ff;
        nxt_ir = ir_ff;
        nxt_ir_valid = ir_valid_ff;
        nxt_stack_top_pointer = stp;
        nxt_ret = ret_ff;
        nxt_status_flags = status_flags_ff;
        nxt_dm_addr = dm_addr_ff;
        nxt_dm_wdata = dm_wdata_ff;
        nxt_dm_we = 1'b0;
        nxt_dm_re = 1'b0;
        nxt_irq_ack = '0;
        nxt_ld_rd = ld_rd_ff;
        nxt_hi_byte = hi_byte_ff;
        nxt_ret_irq = ret_irq_ff;
        rf_we = 1'b0;
        rf_wa = rd;
        rf_wd = alu_res;
        case (state_ff)
            ST_EXEC: begin
                nxt_ir = pm_data; // RULE_01
                nxt_ir_valid = 1'b1;
                nxt_program_counter = program_counter_ff + 16'h0001;
                nxt_pm_addr = program_counter_ff + 16'h0001;
                if (take_irq) begin
                    // status is left as is; handlers save it themselves
                    nxt_status_flags[FL_I] = 1'b0; // RULE_09 RULE_07
                    nxt_irq_ack = irq_pick; // RULE_16
                    nxt_program_counter = vec;
                    nxt_pm_addr = vec;
                    nxt_ir_valid = 1'b0;
                    nxt_ret = program_counter_ff - 16'h0001;
                end else if (ir_valid_ff) begin
                    nxt_status_flags = alu_flags; // RULE_06
                    rf_we = alu_wr; // RULE_03
                    if (two_word) nxt_ir_valid = 1'b0; // RULE_20
                    if (is_load) begin
                        if (op == OP_POP) begin
                            nxt_stack_top_pointer = stp + 16'h0001;
                        end
                        if (int_hit) begin
                            rf_we = 1'b1;
                            rf_wd = int_val;
                        end else begin
                            nxt_dm_addr = ls_addr;
                            nxt_dm_re = 1'b1;
                            nxt_ld_rd = rd;
                            nxt_state = ST_LOAD;
                        end
                    end
                    if (is_store) begin
                        if (op == OP_PUSH) begin
                            nxt_stack_top_pointer = stp - 16'h0001; // RULE_21
                        end
                        if (ls_addr < IO_BASE) begin
                            rf_we = 1'b1;
                            rf_wa = ls_addr[4:0];
                            rf_wd = a;
                        end else if (ls_addr == DA_FLAGS) begin
                            nxt_status_flags = a;
                        end else if (ls_addr == DA_STK_LO) begin
                            nxt_stack_top_pointer[7:0] = a;
                        end else if (ls_addr == DA_STK_HI) begin
                            nxt_stack_top_pointer[15:8] = a;
                        end else begin
                            nxt_dm_addr = ls_addr;
                            nxt_dm_wdata = a;
                            nxt_dm_we = 1'b1;
                        end
                    end
                    if (op == OP_JMP || op == OP_CALL) begin
                        nxt_program_counter = pm_data;
                        nxt_pm_addr = pm_data;
                    end
                    if (op == OP_CALL) nxt_ret = program_counter_ff + 16'h0001;
                    if (op == OP_BRF &&
                        status_flags_ff[bsel] == ir_ff[CND_BIT]) begin
                        nxt_program_counter = program_counter_ff + boff;
                        nxt_pm_addr = program_counter_ff + boff;
                        nxt_ir_valid = 1'b0;
                    end
                    if (op == OP_RET) begin
                        nxt_dm_addr = stp + 16'h0001;
                        nxt_dm_re = 1'b1;
                        nxt_stack_top_pointer = stp + 16'h0001;
                        nxt_ret_irq = ir_ff[0];
                        nxt_state = ST_POP1;
                    end
                    if (op == OP_LPM) begin
                        // flash is word wide; Z bit 0 picks the byte
                        nxt_pm_addr = {1'b0, zptr[15:1]}; // RULE_04
                        nxt_hi_byte = zptr[0];
                        nxt_ld_rd = rd;
                        nxt_state = ST_LPM;
                    end
                end
                if (take_irq || (ir_valid_ff && op == OP_CALL)) begin
                    nxt_dm_addr = stp; // RULE_18
                    nxt_dm_wdata = nxt_ret[7:0];
                    nxt_dm_we = 1'b1;
                    nxt_stack_top_pointer = stp - 16'h0001;
                    nxt_state = ST_PUSH2;
                end
            end
            ST_PUSH2: begin
                nxt_dm_addr = stp;
                nxt_dm_wdata = ret_ff[15:8];
                nxt_dm_we = 1'b1;
                nxt_stack_top_pointer = stp - 16'h0001; // RULE_21
                nxt_state = ST_EXEC;
            end
            ST_POP1: begin
                nxt_ret[15:8] = dm_rdata;
                nxt_dm_addr = stp + 16'h0001;
                nxt_dm_re = 1'b1;
                nxt_stack_top_pointer = stp + 16'h0001;
                nxt_state = ST_POP2;
            end
            ST_POP2: begin
                nxt_program_counter = {ret_ff[15:8], dm_rdata};
                nxt_pm_addr = {ret_ff[15:8], dm_rdata};
                nxt_ir_valid = 1'b0;
                if (ret_irq_ff) nxt_status_flags[FL_I] = 1'b1; // RULE_09
                nxt_state = ST_EXEC;
            end
            ST_LOAD: begin
                rf_we = 1'b1;
                rf_wa = ld_rd_ff;
                rf_wd = dm_rdata;
                nxt_state = ST_EXEC;
            end
            ST_LPM: begin
                rf_we = 1'b1;
                rf_wa = ld_rd_ff;
                rf_wd = hi_byte_ff ? pm_data[15:8] : pm_data[7:0];
                nxt_pm_addr = program_counter_ff;
                nxt_state = ST_EXEC;
            end
            default: nxt_state = ST_EXEC;
        endcase
        // sign is derived, so a direct status write cannot break it
        nxt_status_flags[FL_S] = nxt_status_flags[FL_N]
                                 ^ nxt_status_flags[FL_V]; // RULE_13
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= ST_EXEC;
            program_counter_ff <= PROG_RST;
            pm_addr_ff <= PROG_RST;
            ir_ff <= 16'h0000;
            ir_valid_ff <= 1'b0;
            stack_top_pointer_ff <= STACK_RST;
            ret_ff <= 16'h0000;
            status_flags_ff <= FLAGS_RST; // RULE_22
            dm_addr_ff <= 16'h0000;
            dm_wdata_ff <= 8'h00;
            dm_we_ff <= 1'b0;
            dm_re_ff <= 1'b0;
            irq_ack_ff <= '0;
            ld_rd_ff <= 5'h00;
            hi_byte_ff <= 1'b0;
            ret_irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            program_counter_ff <= nxt_program_counter;
            pm_addr_ff <= nxt_pm_addr;
            ir_ff <= nxt_ir;
            ir_valid_ff <= nxt_ir_valid;
            stack_top_pointer_ff <= nxt_stack_top_pointer;
            ret_ff <= nxt_ret;
            status_flags_ff <= nxt_status_flags;
            dm_addr_ff <= nxt_dm_addr;
            dm_wdata_ff <= nxt_dm_wdata;
            dm_we_ff <= nxt_dm_we;
            dm_re_ff <= nxt_dm_re;
            irq_ack_ff <= nxt_irq_ack;
            ld_rd_ff <= nxt_ld_rd;
            hi_byte_ff <= nxt_hi_byte;
            ret_irq_ff <= nxt_ret_irq;
        end
    end

    for (genvar gi = 0; gi < CPUAS_NREG; gi++) begin : g_gpr
        always_ff @(posedge mclk) begin
            if (rf_we && rf_wa == 5'(gi)) gpr_ff[gi] <= rf_wd; // RULE_02
        end
    end

    AST_SIGN_XOR: assert property ( // RULE_13
        status_flags_ff[FL_S]
        == (status_flags_ff[FL_N] ^ status_flags_ff[FL_V]))
        else $error("sign bit differs from negative xor overflow");
    AST_RESET_CLEAR: assert property ( // RULE_22
        $fell(srst) |-> status_flags_ff == FLAGS_RST && !ir_valid_ff)
        else $error("status not cleared by reset");
    AST_NO_TAKE_DISABLED: assert property ( // RULE_08
        !status_flags_ff[FL_I] |=> irq_ack_ff == '0)
        else $error("interrupt taken with global enable clear");
    AST_TAKE_CLEARS: assert property ( // RULE_09
        irq_ack_ff != '0 |-> !status_flags_ff[FL_I] && state_ff == ST_PUSH2)
        else $error("global enable still set after taking interrupt");
    AST_LOWEST_FIRST: assert property ( // RULE_16
        irq_ack_ff != '0 |-> $onehot(irq_ack_ff)
        && ($past(irq_req) & (irq_ack_ff - 1'b1)) == '0)
        else $error("interrupt served out of priority order");
    AST_RET_PUSH_TWO: assert property ( // RULE_21
        state_ff == ST_PUSH2 |=> stp == $past(stp, 2) - 16'h0002)
        else $error("return push did not lower stack pointer by two");
    AST_DATA_PUSH_ONE: assert property ( // RULE_21
        run && op == OP_PUSH |=> stp == $past(stp) - 16'h0001)
        else $error("data push did not lower stack pointer by one");
    AST_ONE_CYCLE_ALU: assert property ( // RULE_03
        run && op == OP_ADD |=> gpr_ff[$past(rd)] == $past(alu_res)
        && program_counter_ff == $past(program_counter_ff) + 16'h0001)
        else $error("alu result not written back in one cycle");
    AST_TWO_WORD_SKIP: assert property ( // RULE_20
        run && op == OP_LDI |=> !ir_valid_ff ##1 ir_valid_ff)
        else $error("second word of two-word op not skipped");
    AST_RETURN_SETS: assert property ( // RULE_09
        state_ff == ST_POP2 && ret_irq_ff |=> status_flags_ff[FL_I])
        else $error("return from handler did not set global enable");
endmodule : cpuas_core

// file: verification/cpuas_mem_model.sv
// memory model: program rom and data ram on the far side of the core
`timescale 1ns/1ps
module cpuas_mem_model (
    input wire logic mclk,
    input wire logic [15:0] pm_addr,
    output logic [15:0] pm_data,
    input wire logic [15:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we,
    input wire logic dm_re,
    output logic [7:0] dm_rdata
);
    logic [15:0] rom [0:255];
    logic [7:0] ram [0:255];
    // async rom, word valid in the same cycle as the address
    assign pm_data = rom[pm_addr[7:0]];
    // outside a read strobe show inverted data so stale values never match
    assign dm_rdata = dm_re ? ram[dm_addr[7:0]] : ~ram[dm_addr[7:0]];
    always @(posedge mclk) begin
        if (dm_we) begin
            ram[dm_addr[7:0]] <= dm_wdata;
        end
    end
endmodule : cpuas_mem_model

// file: verification/cpu_alu_status_flags_tb_top.sv
// testbench: random adds, flags and two back-to-back interrupt entries
`timescale 1ns/1ps
module cpu_alu_status_flags_tb_top;
    import cpuas_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] irq_req = 8'h00;
    logic [15:0] pm_addr, pm_data, dm_addr;
    logic [7:0] dm_wdata, dm_rdata, status_flags, irq_ack, lfsr, a, b;
    logic dm_we, dm_re;
    logic [15:0] exp_q [$];
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int pc = 0;
    cpuas_core uut (.mclk(mclk), .srst(srst), .pm_addr(pm_addr),
        .pm_data(pm_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata),
        .irq_req(irq_req), .irq_ack(irq_ack), .status_flags(status_flags));
    cpuas_mem_model u_mem (.mclk(mclk), .pm_addr(pm_addr),
        .pm_data(pm_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [7:0] nxt_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt_rand
    task automatic emit(input logic [15:0] w);
        u_mem.rom[pc] = w;
        pc++;
    endtask : emit
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // program: load, add, write sum to io 0x00, copy flags out to io 0x01
    task automatic add_case(input logic [7:0] x, input logic [7:0] y,
                            input logic gie);
        logic [8:0] s;
        logic h, v;
        s = {1'b0, x} + {1'b0, y};
        h = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
        v = (x[7] == y[7]) && (s[7] != x[7]);
        emit({OP_LDI, 5'h10, 6'h00});
        emit({8'h00, x});
        emit({OP_LDI, 5'h11, 6'h00});
        emit({8'h00, y});
        emit({OP_ADD, 5'h10, 5'h11, 1'b0});
        emit({OP_OUT, 5'h10, 6'h00});
        emit({OP_IN, 5'h12, IO_FLAGS});
        emit({OP_OUT, 5'h12, 6'h01});
        exp_q.push_back({8'h20, s[7:0]});
        exp_q.push_back({8'h21, gie, 1'b0, h, s[7] ^ v, v, s[7],
                         s[7:0] == 8'h00, s[8]});
    endtask : add_case
    // every data write is one result; oldest note is the expectation
    task automatic watch();
        logic [15:0] sw, nw;
        sw = {dm_addr[7:0], dm_wdata};
        nw = 16'h0000;
        if (exp_q.size() == 0) begin
            errors++;
        end else begin
            nw = exp_q.pop_front();
        end
        if (nw[15:8] == 8'h21) begin
            check("flags", nw, sw);
        end else if (nw[15:8] == 8'h20) begin
            check("sum", nw, sw);
        end else begin
            check("stack", nw, sw);
        end
    endtask : watch
    always @(posedge mclk) begin
        if (!srst && dm_we) begin
            watch();
        end
    end
    // a source drops its request once its acknowledge arrives
    always @(posedge mclk) begin
        if (!srst && irq_ack != 8'h00) begin
            check("ack", {8'h00, irq_req & (~irq_req + 8'h01)},
                  {8'h00, irq_ack});
            irq_req <= irq_req & ~irq_ack;
        end
    end
    // program runs in well under 400 cycles; ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        lfsr = 8'h54;
        // reset vector jumps over the vector table
        emit({OP_JMP, 11'h000});
        emit(16'h0020);
        pc = 32;
        // sources 2 and 3: one output write each, then return from handler
        u_mem.rom[3 * VEC_WORDS] = {OP_OUT, 5'h14, 6'h02};
        u_mem.rom[3 * VEC_WORDS + 1] = {OP_RET, 10'h000, 1'b1};
        u_mem.rom[4 * VEC_WORDS] = {OP_OUT, 5'h14, 6'h03};
        u_mem.rom[4 * VEC_WORDS + 1] = {OP_RET, 10'h000, 1'b1};
        // stack is placed before interrupts can be enabled
        emit({OP_LDI, 5'h14, 6'h00});
        emit(16'h00ff);
        emit({OP_OUT, 5'h14, IO_STK_LO});
        emit({OP_PUSH, 5'h14, 6'h00});
        exp_q.push_back(16'hffff);
        for (int i = 0; i < 8; i++) begin
            a = lfsr;
            b = nxt_rand(lfsr);
            lfsr = nxt_rand(b);
            if (i == 0) begin
                a = 8'h80;
                b = 8'h80;
            end
            if (i == 7) begin
                emit({OP_GIE, 10'h000, 1'b1});
                // both pend: source 2 served first, then source 3
                for (int j = 2; j < 4; j++) begin
                    exp_q.push_back({8'hfe, pc[7:0]});
                    exp_q.push_back({8'hfd, pc[15:8]});
                    exp_q.push_back({8'h20 + 8'(j), 8'hff});
                end
            end
            add_case(a, b, i == 7);
        end
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        irq_req <= 8'h0c;
        @(posedge mclk);
        #1 check("flags", 16'h0000, {8'h00, status_flags});
        for (int k = 0; k < 400 && exp_q.size() > 0; k++) begin
            @(posedge mclk);
        end
        if (exp_q.size() > 0) begin
            errors++;
        end
        end_sim();
    end
endmodule : cpu_alu_status_flags_tb_top
